/* File: inc/kbd_encoder_defines.vh */
`ifndef KBD_ENCODER_DEFINES_VH
`define KBD_ENCODER_DEFINES_VH

// Matrix geometry
`define DRIVE_LINES 8
`define SENSE_LINES 11
`define KEYS_PER_GROUP 88
`define TABLE_WORDS 264
`define WORD_BITS 9

// Group base addresses in the code table
`define GROUP_NORMAL 9'h000
`define GROUP_SHIFT 9'h058
`define GROUP_CONTROL 9'h0b0

// Ring counter reset states
`define DRIVE_RESET 8'h01
`define SENSE_RESET 11'h001

// Address step from one drive line to the next
`define ROW_STRIDE 9'h00b

// Clocks a new crosspoint needs before its sense lines can be trusted
`define SYNC_SETTLE 32'h0000_0002

// Debounce time, in microseconds
`define DEBOUNCE_US 5000
`define CLOCK_MHZ 40

`endif

/* File: rtl/key_matrix_encoder.v */
// How it works
// - Code table holds 264 nine-bit words in three 88-word groups.
// - Table address is mode group plus position of both ring counters.
// - 8-stage drive ring and 11-stage sense ring cover 88 crosspoints.
// - With no key down both rings step and strobe stays inactive.
// - Match when active sense line equals sense ring stage; halts rings, arms strobe.
// - Strobe is flagged only after the closure persists through a delay.
// - On a match the rings halt; once the delay has run, outputs settle to the word.
// - Code outputs stay unchanged while the detected key stays closed and the mode and polarity selects hold.
// - Data/strobe invert input XORs eight data bits and strobe.
// - Parity invert input XORs the parity output only.
// - Each word is eight data bits plus parity, fixed at build time.
// - Default contents are the word address, bit 6 flipped in shift and control groups, with odd parity.
`timescale 1ns/1ps
`include "kbd_encoder_defines.vh"

// Scan timing: every crosspoint is held for three clocks, because the sense
// lines need two flops before the comparator may trust them. A full pass
// over all crosspoints therefore takes three clocks per key.
// Only one closed key is resolved at a time; the first one found in scan
// order wins and every other key is ignored until that one opens again.
// Shift and control together are not flagged; the control group is used,
// since any code is as good as another for an illegal mode.
// The debounce count runs on the main clock; its default spans 5 ms.
// Limitation: a key that bounces open during the hold looks like a release,
// so a very noisy switch may be reported twice.
// Trade-off: the hold path re-applies polarity every clock, so a select that
// moves while a key is held shows at once rather than on the next key.

module key_matrix_encoder #(
   parameter DEBOUNCE_CYCLES = (`DEBOUNCE_US * `CLOCK_MHZ)
) (
   // Clock and reset
   input wire mclk_i,
   input wire reset_n_i,
   // Mode and polarity selects
   input wire shift_i,
   input wire control_i,
   input wire data_strobe_invert_i,
   input wire parity_invert_i,
   // Keyboard matrix
   input wire [`SENSE_LINES-1:0] matrix_sense_lines_i,
   output reg [`DRIVE_LINES-1:0] matrix_drive_lines_o,
   // Encoded key
   output reg [`WORD_BITS-1:0] key_code_outputs_o,
   output reg strobe_o
);

   localparam ST_SCAN = 2'b00;
   localparam ST_DEBOUNCE = 2'b01;
   localparam ST_HOLD = 2'b10;

   // Fixed table: 8-bit code from group/key index, ninth bit odd parity
   function [`WORD_BITS-1:0] table_word;
      input [8:0] addr;
      reg [7:0] code;
      reg upper;
      begin
         upper = (addr >= `GROUP_SHIFT); // Shift and control groups
         code = addr[7:0] ^ {1'b0, upper, 6'h00};
         table_word = {~(^code), code};
      end
   endfunction

   // Shared select flips data bits, its own select flips parity
   function [`WORD_BITS-1:0] apply_polarity;
      input [`WORD_BITS-1:0] word;
      input data_inv;
      input par_inv;
      begin
         apply_polarity = word ^ {par_inv, {8{data_inv}}};
      end
   endfunction

   // Drive ring rotates left by one line
   function [`DRIVE_LINES-1:0] drive_step;
      input [`DRIVE_LINES-1:0] ring;
      begin
         drive_step = {ring[`DRIVE_LINES-2:0], ring[`DRIVE_LINES-1]};
      end
   endfunction

   // Sense ring shifts up, wrapping from the last stage to the first
   function [`SENSE_LINES-1:0] sense_step;
      input [`SENSE_LINES-1:0] ring;
      begin
         if (ring[`SENSE_LINES-1]) begin
            sense_step = `SENSE_RESET;
         end else begin
            sense_step = {ring[`SENSE_LINES-2:0], 1'b0};
         end
      end
   endfunction

   // One-hot ring to binary index
   function [3:0] onehot_index;
      input [10:0] ring;
      integer k;
      begin
         onehot_index = 4'h0;
         for (k = 0; k < 11; k = k + 1) begin
            if (ring[k]) begin
               onehot_index = k[3:0];
            end
         end
      end
   endfunction

   reg [`SENSE_LINES-1:0] sense_meta;
   reg [`SENSE_LINES-1:0] sense_sync;
   reg [`SENSE_LINES-1:0] sense_ring;
   reg [1:0] state;
   reg [31:0] delay_count;
   reg [`WORD_BITS-1:0] code_rom [0:`TABLE_WORDS-1];
   wire [`WORD_BITS-1:0] addressed_word;
   reg [8:0] group_base;
   reg [8:0] word_addr;
   wire match;
   integer i;

   // Mask contents are fixed at build time; nothing writes them afterwards
   initial begin
      for (i = 0; i < `TABLE_WORDS; i = i + 1) begin
         code_rom[i] = table_word(i[8:0]);
      end
   end

   // Word picked by the mode group and both ring positions
   assign addressed_word = code_rom[word_addr];

   // Mode group select; both asserted is illegal and picks control
   always @* begin
      if (control_i) begin
         group_base = `GROUP_CONTROL;
      end else if (shift_i) begin
         group_base = `GROUP_SHIFT;
      end else begin
         group_base = `GROUP_NORMAL;
      end
   end

   // Word address from both ring positions
   always @* begin
      word_addr = group_base + {5'h00, onehot_index({3'h0, matrix_drive_lines_o})} * `ROW_STRIDE
         + {5'h00, onehot_index(sense_ring)};
   end

   // Active sense stage sees the driven line through a closed key
   assign match = |(sense_sync & sense_ring);

   // Sense pins come from the matrix, so synchronise first
   always @(posedge mclk_i) begin
      if (!reset_n_i) begin
         sense_meta <= {`SENSE_LINES{1'b0}};
         sense_sync <= {`SENSE_LINES{1'b0}};
      end else begin
         sense_meta <= matrix_sense_lines_i;
         sense_sync <= sense_meta;
      end
   end

   // Scan, debounce and hold; the sync delay means a match is checked a
   // few cycles late, so the ring stalls while checking to stay aligned
   always @(posedge mclk_i) begin
      if (!reset_n_i) begin
         state <= ST_SCAN;
         matrix_drive_lines_o <= `DRIVE_RESET;
         sense_ring <= `SENSE_RESET;
         delay_count <= 32'h0000_0000;
         key_code_outputs_o <= {`WORD_BITS{1'b0}};
         strobe_o <= 1'b0;
      end else begin
         case (state)
            // Dwell on each crosspoint until the synchronised sense is valid
            ST_SCAN: begin
               strobe_o <= data_strobe_invert_i;
               if (delay_count < `SYNC_SETTLE) begin
                  delay_count <= delay_count + 32'h0000_0001; // Settle sync
               end else if (match) begin
                  state <= ST_DEBOUNCE;
                  delay_count <= 32'h0000_0000;
               end else begin
                  delay_count <= 32'h0000_0000;
                  sense_ring <= sense_step(sense_ring);
                  if (sense_ring[`SENSE_LINES-1]) begin
                     matrix_drive_lines_o <= drive_step(matrix_drive_lines_o);
                  end
               end
            end
            // Rings stay frozen; the closure must last the whole count
            ST_DEBOUNCE: begin
               strobe_o <= data_strobe_invert_i;
               if (!match) begin
                  state <= ST_SCAN;
                  delay_count <= 32'h0000_0000;
               end else if (delay_count >= DEBOUNCE_CYCLES - 1) begin
                  state <= ST_HOLD;
                  key_code_outputs_o <= apply_polarity(addressed_word, data_strobe_invert_i,
                     parity_invert_i);
                  strobe_o <= ~data_strobe_invert_i;
               end else begin
                  delay_count <= delay_count + 32'h0000_0001;
               end
            end
            // Key reported; wait for it to open before scanning on
            ST_HOLD: begin
               if (!match) begin
                  state <= ST_SCAN;
                  delay_count <= 32'h0000_0000;
                  strobe_o <= data_strobe_invert_i;
               end else begin
                  strobe_o <= ~data_strobe_invert_i;
                  key_code_outputs_o <= apply_polarity(addressed_word, data_strobe_invert_i,
                     parity_invert_i);
               end
            end
            default: begin
               state <= ST_SCAN;
            end
         endcase
      end
   end

endmodule // key_matrix_encoder

/* File: tb/kbd_encoder_properties.sv */
`timescale 1ns/1ps
module kbd_encoder_properties #(parameter DEBOUNCE_CYCLES = 4) (
   input wire mclk_i,
   input wire reset_n_i,
   input wire shift_i,
   input wire control_i,
   input wire data_strobe_invert_i,
   input wire parity_invert_i,
   input wire [10:0] matrix_sense_lines_i,
   input wire [7:0] matrix_drive_lines_o,
   input wire [8:0] key_code_outputs_o,
   input wire strobe_o
);
   reg inv_q;
   reg pinv_q;
   // Outputs are registered, so they carry last cycle's selects
   always @(posedge mclk_i) begin
      inv_q <= data_strobe_invert_i;
      pinv_q <= parity_invert_i;
   end
   wire act = strobe_o ^ inv_q;
   wire key = |matrix_sense_lines_i;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   drive_one_hot_a: assert property ($onehot(matrix_drive_lines_o)) else $error("drive not one-hot");
   strobe_cause_a: assert property (act |-> key || $past(key) || $past(key, 2) || $past(key, 3))
      else $error("strobe without key");
   debounce_hold_a: assert property ($rose(act) |-> $past(key, 2) && $past(key, 3) && $past(key, 4)
      && $past(key, 5)) else $error("strobe before debounce");
   ring_frozen_a: assert property (act && $past(act) |-> $stable(matrix_drive_lines_o))
      else $error("ring moved while valid");
   code_stable_a: assert property (act && $past(act) |-> $stable(key_code_outputs_o))
      else $error("code moved while valid");
   release_drop_a: assert property ((!key)[*4] |=> !act) else $error("strobe stuck");
   parity_sense_a: assert property (act |-> (^key_code_outputs_o) == !pinv_q)
      else $error("parity wrong");
   scan_idle_a: assert property ($changed(matrix_drive_lines_o) |-> !act)
      else $error("scan while valid");
   cover property ($rose(act));
   cover property (act && shift_i);
   cover property (act && control_i);
endmodule // kbd_encoder_properties
bind key_matrix_encoder kbd_encoder_properties #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_props (
   .mclk_i(mclk_i), .reset_n_i(reset_n_i), .shift_i(shift_i), .control_i(control_i),
   .data_strobe_invert_i(data_strobe_invert_i), .parity_invert_i(parity_invert_i),
   .matrix_sense_lines_i(matrix_sense_lines_i), .matrix_drive_lines_o(matrix_drive_lines_o),
   .key_code_outputs_o(key_code_outputs_o), .strobe_o(strobe_o));

/* File: tb/kbd_matrix_model.sv */
`timescale 1ns/1ps
module kbd_matrix_model (
   input wire [7:0] drive_i,
   input wire press_i,
   input wire [3:0] row_i,
   input wire [3:0] col_i,
   output wire [10:0] sense_o
);
   // One closed switch joins its drive line to one sense line; open lines sit pulled low
   assign sense_o = (press_i && drive_i[row_i[2:0]]) ? (11'h001 << col_i) : 11'h000;
endmodule // kbd_matrix_model

/* File: tb/keyboard_matrix_scan_encoder_bench.sv */
`timescale 1ns/1ps
module keyboard_matrix_scan_encoder_bench;
   reg clk = 0, rst_n = 0, shift = 0, ctrl = 0, dinv = 0, pinv = 0, press = 0;
   reg [3:0] j = 0, k = 0;
   reg [1:0] m = 0;
   reg [31:0] r;
   integer seed = 80963, miscompares = 0, tests_run = 0, i, n;
   wire [7:0] drive;
   wire [10:0] sense;
   wire [8:0] code;
   wire strobe;
   key_matrix_encoder #(.DEBOUNCE_CYCLES(4)) u_dut (.mclk_i(clk), .reset_n_i(rst_n),
      .shift_i(shift), .control_i(ctrl), .data_strobe_invert_i(dinv), .parity_invert_i(pinv),
      .matrix_sense_lines_i(sense), .matrix_drive_lines_o(drive), .key_code_outputs_o(code),
      .strobe_o(strobe));
   kbd_matrix_model u_keys (.drive_i(drive), .press_i(press), .row_i(j), .col_i(k),
      .sense_o(sense));
   initial begin
      forever #12.5 clk = ~clk;
   end
   // Word index, bit 6 flipped outside normal mode, odd parity, then polarity
   function [8:0] exp_code(input [3:0] x, input [3:0] y, input [1:0] md);
      reg [8:0] a;
      reg [7:0] c;
      begin
         a = md * 88 + x * 11 + y;
         c = a[7:0] ^ ((md != 0) ? 8'h40 : 8'h00);
         exp_code = {~^c ^ pinv, c ^ {8{dinv}}};
      end
   endfunction
   task check(input ok, input [8*16-1:0] msg);
      begin
         tests_run = tests_run + 1;
         if (ok !== 1'b1) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: %0s", $time, msg);
         end
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", tests_run, miscompares);
         if (miscompares == 0 && tests_run > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   // Corner keys first, then random keys; modes cycle so each group is hit
   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1;
      for (i = 0; i < 15; i = i + 1) begin
         r = $random(seed);
         j = (i == 0) ? 4'h0 : (i == 1) ? 4'h7 : {1'b0, r[2:0]};
         k = (i == 0) ? 4'h0 : (i == 1) ? 4'ha : r[7:4] % 11;
         m = i % 3;
         shift = (m == 1);
         ctrl = (m == 2);
         dinv = r[8];
         pinv = r[9];
         repeat (2) @(negedge clk);
         press = 1;
         n = 0;
         while (strobe === dinv && n < 400) begin
            @(negedge clk);
            n = n + 1;
         end
         check(n < 400 && code === exp_code(j, k, m), "key code");
         repeat (8) @(negedge clk);
         check(code === exp_code(j, k, m) && drive === (8'h01 << j), "held code");
         press = 0;
         repeat (6) @(negedge clk);
         check(strobe === dinv, "strobe released");
      end
      repeat (300) @(negedge clk);
      check(strobe === dinv, "idle strobe");
      summarize;
   end
   // Hang guard, well beyond the expected run of a few thousand cycles
   initial begin
      #1000000;
      miscompares = miscompares + 1;
      summarize;
   end
endmodule // keyboard_matrix_scan_encoder_bench
